// >>> pkg/tsf_map.svh
/*
 * register map, bit positions and per-register masks of the timer status flag block.
 * assumes a 32-bit apb with byte addresses; included by bare name.
 */
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH

`define TSF_ADDR_W      12
`define TSF_NUM_REGS    7
`define TSF_STAT_BASE   12'h000
`define TSF_IEN_BASE    12'h020

// register indices (word index inside each bank)
`define TSF_IDX_EXT0    5
`define TSF_IDX_CH5     6

// bit positions, channels 0 to 4
`define TSF_BIT_DIR     7
`define TSF_BIT_FIX1    6
`define TSF_BIT_UNF     5
`define TSF_BIT_OVF     4

// flag bits that exist in each register
`define TSF_IMPL_CH0    8'h1F
`define TSF_IMPL_CH12   8'h33
`define TSF_IMPL_CH34   8'h1F
`define TSF_IMPL_EXT0   8'h03
`define TSF_IMPL_CH5    8'h07

// bits that always read 1
`define TSF_ONES_CH0    8'hC0
`define TSF_ONES_CH14   8'h40
`define TSF_ONES_EXT0   8'hC0
`define TSF_ONES_CH5    8'h00

// flags that the transfer controller may clear
`define TSF_AUTO_CH04   8'h0F
`define TSF_AUTO_EXT0   8'h00
`define TSF_AUTO_CH5    8'h07

`define TSF_BYTE_ZERO   8'h00
`define TSF_WORD_ZERO   32'h0000_0000

`endif

// >>> pkg/tsf_pkg.sv
/*
 * types of the timer status flag block.
 * assumes tsf_map.svh for every number.
 */
package tsf_pkg;

    typedef logic [7:0] tsf_byte_t;

    // events and modes from one of the counter channels 0 to 4
    typedef struct packed {
        logic       ovf;
        logic       unf;
        logic       cpwm_unf;
        logic       phase_mode;
        logic       cpwm_mode;
        logic [3:0] match;
        logic [3:0] capture;
        logic [3:0] is_capture;
    } tsf_chan_evt_t;

    // events and modes of the u/v/w sub-channels, bit 2 = u
    typedef struct packed {
        logic [2:0] match;
        logic [2:0] capture;
        logic [2:0] pulse_xfer;
        logic [2:0] is_capture;
        logic [2:0] is_pulse;
    } tsf_ch5_evt_t;

endpackage

// >>> src/tsf_top.sv
/*
 * status flag registers of a six-channel timer, apb slave, with auto clear from
 * the transfer and dma controllers and gated interrupt requests.
 * assumes event inputs come from counter logic on clk_i, one-cycle pulses.
 */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tsf_map.svh"

module tsf_top
    import tsf_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [`TSF_ADDR_W-1:0]    paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire tsf_chan_evt_t [4:0]       chan_evt_i,
    input  wire logic [1:0]                ch0_ef_match_i,
    input  wire tsf_ch5_evt_t              ch5_evt_i,
    input  wire logic [4:0]                count_up_i,
    input  wire logic [6:0][7:0]           dtc_ack_i,
    input  wire logic [6:0][7:0]           interrupt_disable_select_i,
    input  wire logic [4:0]                dma_ack_i,
    output logic      [6:0][7:0]           irq_o
);

    localparam logic [6:0][7:0] IMPL = {`TSF_IMPL_CH5, `TSF_IMPL_EXT0, `TSF_IMPL_CH34, `TSF_IMPL_CH34,
                                        `TSF_IMPL_CH12, `TSF_IMPL_CH12, `TSF_IMPL_CH0};
    localparam logic [6:0][7:0] ONES = {`TSF_ONES_CH5, `TSF_ONES_EXT0, `TSF_ONES_CH14, `TSF_ONES_CH14,
                                        `TSF_ONES_CH14, `TSF_ONES_CH14, `TSF_ONES_CH0};
    localparam logic [6:0][7:0] AUTO = {`TSF_AUTO_CH5, `TSF_AUTO_EXT0, `TSF_AUTO_CH04, `TSF_AUTO_CH04,
                                        `TSF_AUTO_CH04, `TSF_AUTO_CH04, `TSF_AUTO_CH04};

    // one-hot word select inside a bank of seven registers
    function automatic logic [6:0] bank_sel(input logic [`TSF_ADDR_W-1:0] a,
                                            input logic [`TSF_ADDR_W-1:0] base);
        logic hit;
        hit = (a[`TSF_ADDR_W-1:5] == base[`TSF_ADDR_W-1:5]) && (a[1:0] == 2'b00) && (a[4:2] != 3'b111);
        bank_sel = hit ? (7'h01 << a[4:2]) : 7'h00;
    endfunction

    logic [6:0][7:0] flags_q;
    logic [6:0][7:0] flags_d;
    logic [6:0][7:0] arm_q;
    logic [6:0][7:0] arm_d;
    logic [6:0][7:0] ien_q;
    logic [6:0][7:0] ien_d;
    logic [6:0][7:0] irq_q;
    logic [6:0][7:0] set_v;
    logic [6:0][7:0] clr_v;
    logic [6:0][7:0] wr0_v;
    logic [6:0][7:0] rd_val;
    logic [31:0]     prdata_q;
    logic [31:0]     prdata_d;
    logic            pready_q;
    logic            pslverr_q;
    logic            pslverr_d;

    wire logic       apb_setup = psel_i & ~penable_i;
    wire logic       apb_acc   = psel_i & penable_i & pready_q;
    wire logic       apb_wr    = apb_acc & pwrite_i;
    wire logic       apb_rd    = apb_acc & ~pwrite_i;
    wire logic [6:0] stat_sel  = bank_sel(paddr_i, `TSF_STAT_BASE);
    wire logic [6:0] ien_sel   = bank_sel(paddr_i, `TSF_IEN_BASE);
    wire logic [6:0] wr_stat   = apb_wr ? stat_sel : 7'h00;
    wire logic [6:0] rd_stat   = apb_rd ? stat_sel : 7'h00;
    wire logic [6:0] wr_ien    = apb_wr ? ien_sel : 7'h00;
    wire logic [7:0] wbyte     = pwdata_i[7:0];

    // set conditions per register
    always_comb begin
        set_v = '0;
        for (int c = 0; c < 5; c++) begin
            set_v[c][`TSF_BIT_OVF] = chan_evt_i[c].ovf
                                   | ((c == 4) & chan_evt_i[c].cpwm_mode & chan_evt_i[c].cpwm_unf);
            set_v[c][`TSF_BIT_UNF] = chan_evt_i[c].unf & chan_evt_i[c].phase_mode;
            for (int g = 0; g < 4; g++) begin
                set_v[c][g] = chan_evt_i[c].is_capture[g] ? chan_evt_i[c].capture[g]
                                                          : chan_evt_i[c].match[g];
            end
            set_v[c] = set_v[c] & IMPL[c];
        end
        set_v[`TSF_IDX_EXT0] = {6'b00_0000, ch0_ef_match_i};
        for (int u = 0; u < 3; u++) begin
            set_v[`TSF_IDX_CH5][u] = ch5_evt_i.is_pulse[u]   ? ch5_evt_i.pulse_xfer[u]
                                   : ch5_evt_i.is_capture[u] ? ch5_evt_i.capture[u]
                                   :                           ch5_evt_i.match[u];
        end
    end

    // automatic clears from the transfer and dma controllers
    always_comb begin
        for (int r = 0; r < `TSF_NUM_REGS; r++) begin
            clr_v[r] = dtc_ack_i[r] & ~interrupt_disable_select_i[r] & AUTO[r];
        end
        for (int c = 0; c < 5; c++) begin
            clr_v[c][0] = clr_v[c][0] | dma_ack_i[c];
        end
    end

    // read view; bit 7 of channels 1 to 4 follows the counter, fixed bits are constant
    always_comb begin
        for (int r = 0; r < `TSF_NUM_REGS; r++) begin
            rd_val[r] = ONES[r] | (flags_q[r] & IMPL[r]);
        end
        for (int c = 1; c < 5; c++) begin
            rd_val[c][`TSF_BIT_DIR] = count_up_i[c];
        end
        rd_val[0][`TSF_BIT_DIR] = 1'b1;
    end

    // flag update: a write-0 clear needs an armed bit, controller clears do not, set always wins
    always_comb begin
        for (int r = 0; r < `TSF_NUM_REGS; r++) begin
            wr0_v[r]   = {8{wr_stat[r]}} & ~wbyte & arm_q[r] & IMPL[r];
            flags_d[r] = (set_v[r] | (flags_q[r] & ~(wr0_v[r] | clr_v[r]))) & IMPL[r];
            // a set after the read disarms, so a stale write-0 is harmless
            arm_d[r]   = IMPL[r] & ~set_v[r]
                       & ((rd_stat[r] ? prdata_q[7:0] : `TSF_BYTE_ZERO)
                          | (arm_q[r] & ~{8{wr_stat[r]}}));
            ien_d[r]   = wr_ien[r] ? (wbyte & IMPL[r]) : ien_q[r];
        end
    end

    // read data is latched in the setup cycle, so every access finishes without wait
    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (apb_setup) begin
            prdata_d  = `TSF_WORD_ZERO;
            pslverr_d = ~|(stat_sel | ien_sel);
            for (int r = 0; r < `TSF_NUM_REGS; r++) begin
                if (stat_sel[r]) begin
                    prdata_d[7:0] = rd_val[r];
                end
                if (ien_sel[r]) begin
                    prdata_d[7:0] = ien_q[r];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_q <= '0;
            arm_q   <= '0;
            ien_q   <= '0;
        end else begin
            flags_q <= flags_d;
            arm_q   <= arm_d;
            ien_q   <= ien_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_q <= '0;
        end else begin
            irq_q <= flags_q & ien_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q  <= `TSF_WORD_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= apb_setup;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o     = irq_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_set_wins_clear: assert property ((|set_v[1]) |=>
        ((flags_q[1] & $past(set_v[1])) == $past(set_v[1])))
        else $error("set event lost in channel 1 status");

    chk_reserved_cd_zero: assert property ((rd_val[1][3:2] == 2'b00) && (rd_val[2][3:2] == 2'b00)
        && (rd_val[0][`TSF_BIT_UNF] == 1'b0) && (rd_val[3][`TSF_BIT_UNF] == 1'b0))
        else $error("reserved flag bit reads nonzero");

    chk_write_one_keeps: assert property ((wr_stat[0] && (wbyte == 8'hFF) && !(|clr_v[0])) |=>
        ((flags_q[0] & $past(flags_q[0])) == $past(flags_q[0])))
        else $error("writing ones cleared a flag");

    chk_unarmed_no_clear: assert property ((wr_stat[2] && (arm_q[2] == 8'h00) && !(|clr_v[2])) |=>
        ((flags_q[2] & $past(flags_q[2])) == $past(flags_q[2])))
        else $error("write-0 without read cleared a flag");

    chk_read_then_clear: assert property ((rd_stat[3] && prdata_q[0] && !set_v[3][0]) ##1
        (wr_stat[3] && !wbyte[0] && !set_v[3][0] && !clr_v[3][0]) |=> !flags_q[3][0])
        else $error("read-1 write-0 did not clear flag a");

    chk_irq_gate_off: assert property ((ien_q[2] == 8'h00) && ($past(ien_q[2]) == 8'h00) |->
        (irq_o[2] == 8'h00))
        else $error("request raised while disabled");

    chk_dir_fixed_bits: assert property ((rd_val[1][7] == count_up_i[1]) && (rd_val[0][7:6] == 2'b11)
        && (rd_val[4][6] == 1'b1) && (rd_val[`TSF_IDX_EXT0][7:2] == 6'b11_0000)
        && (rd_val[`TSF_IDX_CH5][7:3] == 5'b0_0000))
        else $error("fixed status bits wrong");

    chk_dma_clear_a: assert property ((dma_ack_i[0] && !set_v[0][0]) |=> !flags_q[0][0])
        else $error("dma service did not clear flag a");

    chk_dtc_clear_u: assert property ((dtc_ack_i[6][2] && !interrupt_disable_select_i[6][2] && !set_v[6][2])
        |=> !flags_q[6][2])
        else $error("transfer service did not clear flag u");

    chk_cpwm_ovf_set: assert property ((chan_evt_i[4].cpwm_mode && chan_evt_i[4].cpwm_unf)
        |=> flags_q[4][`TSF_BIT_OVF] ##1 (irq_o[4][`TSF_BIT_OVF] == $past(ien_q[4][`TSF_BIT_OVF])))
        else $error("channel 4 overflow flag not set in complementary pwm");

    chk_apb_no_wait: assert property (apb_setup |=> (pready_o && !$past(pready_o)))
        else $error("access phase not ready");

    cov_read_clear: cover property (rd_stat[0] && prdata_q[0] ##1 wr_stat[0] && !wbyte[0]);
    cov_set_during_clear: cover property (wr0_v[1][4] && set_v[1][4]);
    cov_dma_clear: cover property (flags_q[0][0] && dma_ack_i[0]);
    cov_irq_raise: cover property ($rose(irq_o[6][0]));

endmodule
`default_nettype wire

// >>> sim/tsf_xfer_model.sv
/*
 * model of the transfer and dma controllers that serve the flag interrupts.
 * assumes irq_i is registered and stays up until the served flag is cleared.
 */
`timescale 1ns/10ps
`default_nettype none
module tsf_xfer_model (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic [6:0][7:0] irq_i,
    input  wire logic            dtc_en_i,
    input  wire logic            dma_en_i,
    output logic      [6:0][7:0] dtc_ack_o,
    output logic      [4:0]      dma_ack_o
);
    // ack every other cycle at most: irq lags the clear by one cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dtc_ack_o <= '0;
            dma_ack_o <= '0;
        end else begin
            dtc_ack_o <= dtc_en_i ? (irq_i & ~dtc_ack_o) : '0;
            for (int i = 0; i < 5; i++) begin
                dma_ack_o[i] <= dma_en_i & irq_i[i][0] & ~dma_ack_o[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb.sv
/*
 * self-checking bench of the timer status flag block over apb.
 * assumes zero-wait apb answers and one-cycle event pulses on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tsf_map.svh"
module tb
    import tsf_pkg::*;
;
    logic                   clk_i;
    logic                   rst_n_i;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`TSF_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    tsf_chan_evt_t [4:0]    chan;
    logic [1:0]             ef;
    tsf_ch5_evt_t           c5;
    logic [4:0]             cup;
    logic [6:0][7:0]        dtc_ack;
    logic [6:0][7:0]        interrupt_disable_select;
    logic [6:0][7:0]        irq;
    logic [4:0]             dma_ack;
    logic                   dtc_en;
    logic                   dma_en;
    logic                   hit;
    logic [31:0]            rd;
    logic                   err;
    int                     n_errors = 0;
    int                     n_checks = 0;

    tsf_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .chan_evt_i(chan), .ch0_ef_match_i(ef), .ch5_evt_i(c5), .count_up_i(cup), .dtc_ack_i(dtc_ack),
        .interrupt_disable_select_i(interrupt_disable_select), .dma_ack_i(dma_ack), .irq_o(irq));
    tsf_xfer_model ctl (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_i(irq), .dtc_en_i(dtc_en), .dma_en_i(dma_en),
        .dtc_ack_o(dtc_ack), .dma_ack_o(dma_ack));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // starts right after an edge, ends one idle edge after the answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk_i);
        penable <= 1'b1;
        if (hit) begin
            chan[3].capture[0] <= 1'b1;
        end
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            print_verdict();
        end else begin
            rd  = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            chan[3].capture[0] <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h00_0000, e}, rd);
    endtask

    // one clock, then every event pulse drops
    task automatic step;
        @(posedge clk_i);
        for (int i = 0; i < 5; i++) begin
            chan[i].ovf      <= 1'b0;
            chan[i].unf      <= 1'b0;
            chan[i].cpwm_unf <= 1'b0;
            chan[i].match    <= 4'h0;
            chan[i].capture  <= 4'h0;
        end
        ef <= 2'h0;
        c5 <= c5 & {3'h0, 3'h0, 3'h0, 3'h7, 3'h7};
    endtask

    initial begin
        rst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        chan = '0;
        chan[1].phase_mode = 1'b1;
        chan[3].phase_mode = 1'b1;
        chan[4].cpwm_mode = 1'b1;
        chan[3].is_capture = 4'hF;
        ef = 2'h0;
        c5 = '0;
        c5.is_capture = 3'h2;
        c5.is_pulse = 3'h1;
        cup = 5'h0A;
        interrupt_disable_select = '0;
        dtc_en = 1'b0;
        dma_en = 1'b0;
        hit = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rchk("ch0", 12'h000, 8'hC0);
        rchk("ch1", 12'h004, 8'hC0);
        rchk("ch2", 12'h008, 8'h40);
        rchk("ext0", 12'h014, 8'hC0);
        rchk("ch5", 12'h018, 8'h00);
        rchk("en3", 12'h02C, 8'h00);
        apb(1'b0, 12'h040, 8'h00);
        chk("err", 32'h0000_0001, {31'h0, err});
        chan[0].ovf <= 1'b1;
        chan[0].match <= 4'hF;
        chan[1].unf <= 1'b1;
        chan[1].match <= 4'hF;
        chan[3].unf <= 1'b1;
        chan[3].capture <= 4'hF;
        chan[4].cpwm_unf <= 1'b1;
        ef <= 2'h3;
        c5 <= c5 | {3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
        step();
        rchk("ch0", 12'h000, 8'hDF);
        rchk("ch1", 12'h004, 8'hE3);
        rchk("ch3", 12'h00C, 8'hCF);
        rchk("ch4", 12'h010, 8'h50);
        rchk("ext0", 12'h014, 8'hC3);
        rchk("ch5", 12'h018, 8'h07);
        apb(1'b1, 12'h000, 8'hFF);
        rchk("ch0", 12'h000, 8'hDF);
        apb(1'b1, 12'h000, 8'hFE);
        rchk("ch0", 12'h000, 8'hDE);
        chan[0].match <= 4'h2;
        step();
        apb(1'b1, 12'h000, 8'h00);
        rchk("ch0", 12'h000, 8'hC2);
        hit = 1'b1;
        apb(1'b1, 12'h00C, 8'h00);
        hit = 1'b0;
        rchk("ch3", 12'h00C, 8'hC1);
        apb(1'b1, 12'h020, 8'hFF);
        rchk("en0", 12'h020, 8'h1F);
        apb(1'b1, 12'h034, 8'h03);
        apb(1'b1, 12'h038, 8'h07);
        repeat (2) @(posedge clk_i);
        chk("irq0", 32'h0000_0002, {24'h00_0000, irq[0]});
        chk("irq1", 32'h0000_0000, {24'h00_0000, irq[1]});
        chk("irq6", 32'h0000_0007, {24'h00_0000, irq[6]});
        interrupt_disable_select <= '1;
        dtc_en <= 1'b1;
        repeat (8) @(posedge clk_i);
        rchk("ch0", 12'h000, 8'hC2);
        interrupt_disable_select <= '0;
        repeat (8) @(posedge clk_i);
        rchk("ch0", 12'h000, 8'hC0);
        rchk("ch5", 12'h018, 8'h00);
        rchk("ext0", 12'h014, 8'hC3);
        dtc_en <= 1'b0;
        apb(1'b1, 12'h028, 8'h01);
        chan[2].match <= 4'h1;
        step();
        rchk("ch2", 12'h008, 8'h41);
        dma_en <= 1'b1;
        repeat (8) @(posedge clk_i);
        rchk("ch2", 12'h008, 8'h40);
        dma_en <= 1'b0;
        apb(1'b1, 12'h024, 8'hFF);
        rchk("en1", 12'h024, 8'h33);
        repeat (2) @(posedge clk_i);
        chk("irq1", 32'h0000_0023, {24'h00_0000, irq[1]});
        print_verdict();
    end
endmodule
`default_nettype wire
